// file: sim/spi_peer_model.sv
// behavioural serial peer standing on the far side of the port
`timescale 1ns/1ns
module spi_peer_model (
  input wire logic sck, // serial clock from master
  input wire logic sel, // select from master
  input wire logic mosi, // master-out data
  input wire logic clock_polarity, // clock idle level
  input wire logic clock_phase, // capture on second edge
  input wire logic lsb, // lsb first
  input wire logic sel_high, // select active level
  input wire logic [31:0] word, // justified word to return
  output logic miso, // master-in data
  output logic [31:0] got // bits captured this frame
);
  logic [31:0] sh;
  logic act;
  assign act = (sel === sel_high);
  task automatic put;
    miso = lsb ? sh[0] : sh[31];
    sh = lsb ? sh >> 1 : sh << 1;
  endtask : put
  initial miso = 1'b0;
  always @(posedge act) begin
    sh = word;
    got = 32'h0;
    if (!clock_phase) put();
  end
  // a released line shows the inverse so a stale bit cannot pass
  always @(negedge act) miso = ~miso;
  always @(sck) begin
    if (act && ((sck ^ clock_polarity ^ clock_phase) === 1'b1)) got = lsb ? {mosi, got[31:1]} : {got[30:0], mosi};
    else if (act) put();
  end
endmodule : spi_peer_model

// file: sim/tb_top.sv
// self-checking bench: register access, master frames, slave length errors
`timescale 1ns/1ns
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v, lo, hi, peer_word, peer_got, sgot;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic sck_i, sel_i, mosi_i, miso_i, sck_o, sck_oe, sel_o, sel_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic clock_polarity, clock_phase, lsb, sel_high, sel_seen;
  logic [3:0] cfg [4] = '{4'b0001, 4'b1010, 4'b0111, 4'b1100};
  logic [4:0] code [4] = '{5'h07, 5'h0b, 5'h1f, 5'h01};
  logic [1:0] mode [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
  int len [4] = '{8, 12, 32, 8};
  int num_errors, checks_done, n;
  spi_master_slave_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe), .sel_i(sel_i), .sel_o(sel_o), .sel_oe(sel_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe));
  spi_peer_model peer (.sck(sck_o), .sel(sel_o), .mosi(mosi_o), .clock_polarity(clock_polarity), .clock_phase(clock_phase), .lsb(lsb),
    .sel_high(sel_high), .word(peer_word), .miso(miso_i), .got(peer_got));
  always #25 aclk = ~aclk;
  always @(negedge aclk) if (sel_oe === 1'b1 && sel_o === sel_high) sel_seen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  // ready and valid are stable at the falling edge, so the handshake edge is known beforehand
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic frame(input logic [31:0] txw);
    sel_seen <= 1'b0;
    wr(4'h0, {28'h0, clock_phase, clock_polarity, 2'b11});
    wr(4'hc, txw);
    do rd(4'h0); while (v[25] !== 1'b1 || v[19] !== 1'b0);
    rd(4'h0);
  endtask : frame
  task automatic slave_frame(input int edges, input logic [7:0] b);
    @(posedge aclk);
    sgot = 32'h0;
    sel_i <= 1'b0;
    for (int i = 0; i < edges; i++) begin
      mosi_i <= b[7 - (i % 8)];
      repeat (4) @(posedge aclk);
      sgot = {sgot[30:0], miso_o};
      sck_i <= 1'b1;
      repeat (4) @(posedge aclk);
      sck_i <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    sel_i <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask : slave_frame
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    aclk = 1'b0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sck_i, mosi_i} <= 8'h00;
    {awaddr, araddr, wdata} <= 40'h0;
    wstrb <= 4'hf;
    sel_i <= 1'b1;
    {clock_polarity, clock_phase, lsb, sel_high, sel_seen} = 5'h0;
    peer_word = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h0);
    chk(v, 32'h0, "control reset");
    rd(4'h4);
    chk(v, 32'h0000_0400, "format reset");
    rd(4'h1);
    chk({30'h0, resp}, 32'h2, "unmapped response");
    wr(4'h1, 32'hffff_ffff);
    chk({30'h0, resp}, 32'h0, "unmapped write okay");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      n = len[i];
      {clock_polarity, clock_phase, lsb, sel_high} = cfg[i];
      lo = 32'hffff_ffff >> (32 - n);
      hi = lsb ? lo : lo << (32 - n);
      peer_word = lsb ? (32'h6d24_c3f7 & lo) : (32'h6d24_c3f7 << (32 - n));
      wr(4'h4, {12'h0, sel_high, lsb, mode[i], 8'h03, 3'h0, code[i]});
      wr(4'h0, {28'h0, clock_phase, clock_polarity, 2'b11});
      repeat (4) @(negedge aclk);
      chk({30'h0, sck_o, sel_o}, {30'h0, clock_polarity, ~sel_high}, "idle clock and select");
      frame(lsb ? (32'h9c3e_5ab1 & lo) : (32'h9c3e_5ab1 << (32 - n)));
      chk((lsb ? peer_got >> (32 - n) : peer_got) & lo, 32'h9c3e_5ab1 & lo, "peer received");
      chk(v & 32'h037f_0000, 32'h0301_0000, "flags after frame");
      chk({31'h0, sel_seen}, 32'h1, "select raised");
      rd(4'h8);
      chk(v & hi, peer_word, "received word");
      rd(4'h0);
      chk({31'h0, v[16]}, 32'h0, "full cleared by read");
      $display("test master frame %0d done", i);
    end
    frame(32'h5a00_0000);
    peer_word = 32'h3c00_0000;
    frame(32'h5a00_0000);
    chk({31'h0, v[18]}, 32'h1, "lost set");
    rd(4'h8);
    chk(v & 32'hff00_0000, 32'h3c00_0000, "newest word kept");
    rd(4'h0);
    chk({31'h0, v[18]}, 32'h0, "lost cleared");
    $display("test data lost done");
    wr(4'h4, 32'h0001_0307);
    repeat (4) @(negedge aclk);
    chk({31'h0, sel_oe}, 32'h0, "select released");
    $display("test three wire done");
    wr(4'h4, 32'h0000_0307);
    wr(4'h0, 32'h1);
    repeat (4) @(negedge aclk);
    chk({30'h0, sck_oe, mosi_oe}, 32'h0, "slave drives no master lines");
    foreach (len[k]) begin
      if (k < 3) begin
        slave_frame(k == 0 ? 8 : (k == 1 ? 7 : 9), 8'h96);
        rd(4'h0);
        chk(v & 32'h0230_0000, k == 0 ? 32'h0200_0000 : (k == 1 ? 32'h0210_0000 : 32'h0220_0000),
          "slave flags");
        rd(4'h8);
        if (k == 0) chk(v & 32'hff00_0000, 32'h9600_0000, "slave word");
        wr(4'h0, 32'h1);
        rd(4'h0);
        chk(v & 32'h0330_0000, 32'h0, "flags cleared by zero write");
      end
    end
    $display("test slave lengths done");
    wr(4'h4, 32'h0011_0307);
    wr(4'hc, 32'ha500_0000);
    wr(4'h4, 32'h0001_0307);
    repeat (4) @(negedge aclk);
    chk({31'h0, miso_oe}, 32'h1, "slave drives master-in");
    slave_frame(8, 8'h3c);
    wr(4'h4, 32'h0011_0307);
    rd(4'h8);
    chk(v & 32'hff00_0000, 32'h3c00_0000, "three wire word");
    chk(sgot & 32'hff, 32'ha5, "three wire reply");
    $display("test three wire slave done");
    wrap_up();
  end
endmodule : tb_top

// file: verilog/spi_master_slave_port.sv
// serial peripheral port, master or slave, with AXI4-Lite registers
`timescale 1ns/1ns
`include "spi_port_cfg.svh"
module spi_master_slave_port #(
  parameter int DIV_W = 8 // width of master clock divider
) (
  input wire logic aclk, // system clock 20 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic sck_i, // serial clock in (slave)
  output logic sck_o, // serial clock out
  output logic sck_oe, // serial clock drive enable
  input wire logic sel_i, // select in (slave)
  output logic sel_o, // select out
  output logic sel_oe, // select drive enable
  input wire logic mosi_i, // master-out line in (slave)
  output logic mosi_o, // master-out line out
  output logic mosi_oe, // master-out drive enable
  input wire logic miso_i, // master-in line in (master)
  output logic miso_o, // master-in line out
  output logic miso_oe // master-in drive enable
);
  // ---------------- configuration registers
  logic en_q, role_q, clock_polarity_q, clock_phase_q, emu_q, selpol_q, lsb_q;
  logic [1:0] mode_q;
  logic [4:0] len_code_q;
  logic [DIV_W-1:0] div_q;
  logic [31:0] tx_buf_q, rx_buf_q;
  logic tx_full_q, rx_full_q, lost_q, over_q, under_q, busy_q, upd_q, txirq_q, rxirq_q;

  function automatic logic [5:0] frame_bits(input logic [4:0] code);
    if (code < `LEN_MIN_CODE)
      return `LEN_DEFAULT;
    return {1'b0, code} + 6'h01;
  endfunction : frame_bits

  // map shift word to justified buffer layout
  function automatic logic [31:0] justify(input logic [31:0] w, input logic [5:0] n, input logic lsb);
    if (lsb)
      return w;
    return w << (6'd32 - n);
  endfunction : justify

  logic [5:0] nbits;
  logic three_wire;
  assign nbits = frame_bits(len_code_q);
  assign three_wire = (mode_q == `MODE_3WIRE);

  // ---------------- AXI4-Lite slave
  logic aw_hold_q, w_hold_q;
  logic [3:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] wstrb_q;
  logic do_wr, do_rd;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign do_wr = aw_hold_q & w_hold_q;
  assign do_rd = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] ctrl_rd, fmt_rd;
  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[`B_EN] = en_q;
    ctrl_rd[`B_ROLE] = role_q;
    ctrl_rd[`B_CLOCK_POLARITY] = clock_polarity_q;
    ctrl_rd[`B_CLOCK_PHASE] = clock_phase_q;
    ctrl_rd[`B_RXFULL] = rx_full_q;
    ctrl_rd[`B_TXFULL] = tx_full_q;
    ctrl_rd[`B_LOST] = lost_q;
    ctrl_rd[`B_BUSY] = busy_q;
    ctrl_rd[`B_UNDER] = under_q;
    ctrl_rd[`B_OVER] = over_q;
    ctrl_rd[`B_UPD] = upd_q;
    ctrl_rd[`B_TXIRQ] = txirq_q;
    ctrl_rd[`B_RXIRQ] = rxirq_q;
    fmt_rd = 32'h0;
    fmt_rd[4:0] = len_code_q;
    fmt_rd[15:8] = 8'(div_q);
    fmt_rd[`B_MODE_LO +: 2] = mode_q;
    fmt_rd[`B_LSB] = lsb_q;
    fmt_rd[`B_SELPOL] = selpol_q;
    fmt_rd[`B_EMU] = emu_q;
  end

  logic rx_read;
  assign rx_read = do_rd && (s_axi_araddr == `OFS_RX);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `OFS_CTRL: s_axi_rdata <= ctrl_rd;
        `OFS_FMT: s_axi_rdata <= fmt_rd;
        `OFS_RX: s_axi_rdata <= rx_buf_q;
        `OFS_TX: s_axi_rdata <= tx_buf_q;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic wr_ctrl, wr_fmt, wr_tx;
  assign wr_ctrl = do_wr && (aw_q == `OFS_CTRL);
  assign wr_fmt = do_wr && (aw_q == `OFS_FMT);
  assign wr_tx = do_wr && (aw_q == `OFS_TX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      role_q <= 1'b0;
      clock_polarity_q <= 1'b0;
      clock_phase_q <= 1'b0;
      emu_q <= 1'b0;
      selpol_q <= 1'b0;
      lsb_q <= 1'b0;
      mode_q <= 2'h0;
      len_code_q <= 5'h0;
      div_q <= DIV_W'(`SCK_DIV_DEF);
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        en_q <= w_q[`B_EN];
        role_q <= w_q[`B_ROLE];
        clock_polarity_q <= w_q[`B_CLOCK_POLARITY];
        clock_phase_q <= w_q[`B_CLOCK_PHASE];
      end
      if (wr_fmt && wstrb_q[0])
        len_code_q <= w_q[4:0];
      if (wr_fmt && wstrb_q[1])
        div_q <= DIV_W'(w_q[15:8]);
      if (wr_fmt && wstrb_q[2]) begin
        mode_q <= w_q[`B_MODE_LO +: 2];
        lsb_q <= w_q[`B_LSB];
        selpol_q <= w_q[`B_SELPOL];
        emu_q <= w_q[`B_EMU];
      end
    end
  end

  // ---------------- input synchronisers (slave pins and master-in)
  logic [1:0] sck_s, sel_s, mosi_s, miso_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s <= 2'h0;
      sel_s <= 2'h0;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[0], sck_i};
      sel_s <= {sel_s[0], sel_i};
      mosi_s <= {mosi_s[0], mosi_i};
      miso_s <= {miso_s[0], miso_i};
    end
  end
  logic sck_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      sck_prev_q <= 1'b0;
    else
      sck_prev_q <= sck_s[1];
  end

  // slave select: emulator bit stands in for the pin in 3-wire mode
  logic s_sel_act;
  // 3-wire slave ignores the clock until software clears the emulator bit
  assign s_sel_act = three_wire ? ~emu_q : (sel_s[1] == selpol_q);

  // ---------------- shift engine shared by both roles
  spi_port_pkg::mstate_t st_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic tick;
  logic m_sck_q;
  logic [31:0] sh_q;
  logic [6:0] edge_cnt_q;
  logic [6:0] edges_n;
  logic s_act_q;
  logic load_sh, cap_done;
  assign tick = (div_cnt_q == '0);
  // two clock edges per bit; seven bits so a 32-bit frame fits
  assign edges_n = {nbits, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == spi_port_pkg::st_idle)
      div_cnt_q <= '0;
    else if (tick)
      div_cnt_q <= div_q;
    else
      div_cnt_q <= div_cnt_q - 1'b1;
  end

  // slave edge stream: leading edge leaves idle level, trailing returns
  logic s_edge;
  assign s_edge = en_q && !role_q && s_sel_act && (sck_s[1] != sck_prev_q);
  logic m_edge;
  assign m_edge = (st_q == spi_port_pkg::st_shift) && tick;
  logic any_edge;
  assign any_edge = role_q ? m_edge : s_edge;
  // capture edge is even count (1st) for phase 0, odd (2nd) for phase 1
  logic cap_edge;
  assign cap_edge = any_edge && (edge_cnt_q[0] == clock_phase_q);
  logic in_bit;
  assign in_bit = role_q ? miso_s[1] : mosi_s[1];

  // master sequence
  logic m_start;
  assign m_start = en_q && role_q && tx_full_q && st_q == spi_port_pkg::st_idle;
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_q || !role_q) begin
      st_q <= spi_port_pkg::st_idle;
      m_sck_q <= 1'b0;
    end else begin
      case (st_q)
        spi_port_pkg::st_idle: if (m_start) st_q <= spi_port_pkg::st_lead;
        spi_port_pkg::st_lead: if (tick) st_q <= spi_port_pkg::st_shift;
        spi_port_pkg::st_shift: begin
          if (tick)
            m_sck_q <= ~m_sck_q;
          if (tick && edge_cnt_q == edges_n - 7'h01)
            st_q <= spi_port_pkg::st_done;
        end
        spi_port_pkg::st_done: if (tick) st_q <= spi_port_pkg::st_idle;
        default: st_q <= spi_port_pkg::st_idle;
      endcase
    end
  end

  // slave load when select becomes active; master load at start
  logic s_act_rise, s_act_fall;
  assign s_act_rise = en_q && !role_q && s_sel_act && !s_act_q;
  assign s_act_fall = en_q && !role_q && !s_sel_act && s_act_q;
  assign load_sh = m_start || s_act_rise;
  logic frame_full;
  assign frame_full = (edge_cnt_q >= edges_n);
  assign cap_done = cap_edge && (edge_cnt_q[6:1] == nbits - 6'd1);

  // shift keeps word right-aligned; direction set by bit order
  logic [31:0] sh_next;
  assign sh_next = lsb_q ? ((sh_q >> 1) | (32'(in_bit) << (nbits - 6'd1))) : {sh_q[30:0], in_bit};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_act_q <= 1'b0;
      edge_cnt_q <= 7'h0;
      sh_q <= 32'h0;
    end else begin
      s_act_q <= en_q && !role_q && s_sel_act;
      if (load_sh) begin
        edge_cnt_q <= 7'h0;
        sh_q <= lsb_q ? tx_buf_q : (tx_buf_q >> (6'd32 - nbits));
      end else if (any_edge && !frame_full) begin
        edge_cnt_q <= edge_cnt_q + 7'h01;
        if (cap_edge)
          sh_q <= sh_next;
      end
    end
  end

  logic out_bit;
  assign out_bit = lsb_q ? sh_q[0] : sh_q[5'(nbits - 6'd1)];

  // ---------------- status flags: hardware set wins over software clear, except lost, which a read in the load cycle clears
  logic rx_load, extra_edge;
  assign rx_load = cap_done || (s_act_fall && !frame_full && edge_cnt_q != 7'h0);
  logic [31:0] rx_word;
  assign rx_word = justify(cap_done ? sh_next : sh_q, nbits, lsb_q);
  assign extra_edge = any_edge && frame_full && (role_q || s_sel_act);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= 32'h0;
      rx_full_q <= 1'b0;
      lost_q <= 1'b0;
      upd_q <= 1'b0;
      rxirq_q <= 1'b0;
    end else begin
      upd_q <= rx_load;
      if (rx_load)
        rx_buf_q <= lsb_q ? rx_word & (32'hffff_ffff >> (6'd32 - nbits)) : rx_word;
      if (rx_load)
        rx_full_q <= 1'b1;
      else if (rx_read)
        rx_full_q <= 1'b0;
      if (rx_load && rx_full_q && !rx_read)
        lost_q <= 1'b1;
      else if (rx_read)
        lost_q <= 1'b0;
      if (rx_load)
        rxirq_q <= 1'b1;
      else if (wr_ctrl && wstrb_q[3] && !w_q[`B_RXIRQ])
        rxirq_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_q <= 32'h0;
      tx_full_q <= 1'b0;
      txirq_q <= 1'b0;
    end else begin
      if (wr_tx)
        tx_buf_q <= w_q;
      if (wr_tx)
        tx_full_q <= 1'b1;
      else if (load_sh)
        tx_full_q <= 1'b0;
      if (load_sh)
        txirq_q <= 1'b1;
      else if (wr_ctrl && wstrb_q[3] && !w_q[`B_TXIRQ])
        txirq_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over_q <= 1'b0;
      under_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (extra_edge)
        over_q <= 1'b1;
      else if (wr_ctrl && wstrb_q[2] && !w_q[`B_OVER])
        over_q <= 1'b0;
      if (s_act_fall && !frame_full)
        under_q <= 1'b1;
      else if (wr_ctrl && wstrb_q[2] && !w_q[`B_UNDER])
        under_q <= 1'b0;
      busy_q <= role_q ? (st_q != spi_port_pkg::st_idle || m_start) : (en_q && s_sel_act);
    end
  end

  // ---------------- pins
  spi_port_pkg::spi_out_t po;
  logic m_active;
  assign m_active = en_q && role_q && st_q != spi_port_pkg::st_idle;
  always_comb begin
    po.sck = m_sck_q ^ clock_polarity_q;
    po.sel = m_active ? selpol_q : ~selpol_q;
    po.mosi = out_bit;
  end
  // data pin lags the clock pin by one cycle so the peer never sees both move together
  logic mosi_d_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o <= 1'b0;
      sel_o <= 1'b0;
      mosi_d_q <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
    end else begin
      sck_o <= po.sck;
      sel_o <= po.sel;
      mosi_d_q <= po.mosi;
      mosi_o <= mosi_d_q;
      miso_o <= out_bit;
    end
  end
  assign sck_oe = en_q && role_q;
  assign mosi_oe = en_q && role_q;
  assign sel_oe = en_q && role_q && !three_wire;
  assign miso_oe = en_q && !role_q && s_sel_act;

  // ---------------- assertions
  a_tx_load_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    load_sh |=> txirq_q && !tx_full_q || $past(wr_tx)) else $error("tx flag not set on load");
  a_rx_load_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_load |=> rxirq_q && rx_full_q && upd_q) else $error("rx load flags missing");
  a_upd_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    upd_q |-> $past(rx_load)) else $error("update flag without load");
  a_lost_set: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_load && rx_full_q && !rx_read |=> lost_q) else $error("lost flag not set");
  a_txfull_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_tx |=> tx_full_q && tx_buf_q == $past(w_q)) else $error("tx full not set");
  a_rxfull_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_read && !rx_load |=> !rx_full_q) else $error("rx full not cleared");
  a_over_set: assert property (@(posedge aclk) disable iff (!aresetn)
    extra_edge |=> over_q) else $error("overrun not flagged");
  a_under_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_act_fall && !frame_full |=> under_q) else $error("underrun not flagged");
  a_sel_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !m_active ##1 !m_active && $stable(selpol_q) |-> sel_o == ~selpol_q) else $error("select not idle");
  a_sck_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == spi_port_pkg::st_idle [*2] ##1 $stable(clock_polarity_q) |-> sck_o == clock_polarity_q) else $error("clock idle level");
  a_len_low: assert property (@(posedge aclk) disable iff (!aresetn)
    len_code_q < `LEN_MIN_CODE |-> nbits == `LEN_DEFAULT) else $error("short code length");
endmodule : spi_master_slave_port

// file: verilog/spi_port_cfg.svh
// register offsets, field positions and timing constants of the serial port
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH
`define OFS_CTRL 4'h0
`define OFS_FMT 4'h4
`define OFS_RX 4'h8
`define OFS_TX 4'hc
`define B_EN 0
`define B_ROLE 1
`define B_CLOCK_POLARITY 2
`define B_CLOCK_PHASE 3
`define B_RXFULL 16
`define B_TXFULL 17
`define B_LOST 18
`define B_BUSY 19
`define B_UNDER 20
`define B_OVER 21
`define B_UPD 22
`define B_TXIRQ 24
`define B_RXIRQ 25
`define B_EMU 20
`define B_SELPOL 19
`define B_LSB 18
`define B_MODE_LO 16
`define MODE_3WIRE 2'h1
`define LEN_MIN_CODE 5'h03
`define LEN_DEFAULT 6'h08
`define SCK_DIV_DEF 8'h04
`endif

// file: verilog/spi_port_pkg.sv
// types shared by the serial port
package spi_port_pkg;
  typedef struct packed {
    logic sck;
    logic sel;
    logic mosi;
  } spi_out_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_lead = 2'b01,
    st_shift = 2'b11,
    st_done = 2'b10
  } mstate_t;
endpackage : spi_port_pkg
